// ===== shared/mxa_pkg.sv
// Shared constants and types for the extended and arithmetic execution unit
package mxa_pkg;

    // APB register byte addresses
    localparam logic [7:0] MXA_CMD_ADDR = 8'h00;
    localparam logic [7:0] MXA_STATUS_ADDR = 8'h04;
    localparam logic [7:0] MXA_WREG_ADDR = 8'h08;
    localparam logic [7:0] MXA_FLAGS_ADDR = 8'h0C;
    localparam logic [7:0] MXA_TABLE_POINTER_REG_ADDR = 8'h10;
    localparam logic [7:0] MXA_TABLE_HIGH_BYTE_REG_ADDR = 8'h14;
    localparam logic [7:0] MXA_PAGE_ADDR = 8'h18;
    localparam logic [7:0] MXA_PC_ADDR = 8'h1C;
    localparam logic [7:0] MXA_DADDR_ADDR = 8'h20;
    localparam logic [7:0] MXA_DDATA_ADDR = 8'h24;
    localparam logic [7:0] MXA_PADDR_ADDR = 8'h28;
    localparam logic [7:0] MXA_PDATA_ADDR = 8'h2C;

    // Command word fields
    localparam int MXA_CMD_ARG_LSB = 0;
    localparam int MXA_CMD_BIT_LSB = 8;
    localparam int MXA_CMD_OP_LSB = 16;

    // Status word fields
    localparam int MXA_ST_BUSY = 0;
    localparam int MXA_ST_SKIP = 1;
    localparam int MXA_ST_CYC_LSB = 4;

    // Flag positions inside the flags byte
    localparam int MXA_F_C = 0;
    localparam int MXA_F_AC = 1;
    localparam int MXA_F_Z = 2;
    localparam int MXA_F_OV = 3;
    localparam int MXA_F_SC = 4;

    // Data memory byte that aliases the program counter low byte
    localparam logic [7:0] MXA_PCL_MEM_ADDR = 8'h02;

    // Cycle counts
    localparam logic [1:0] MXA_CYC_BASIC = 2'h1;
    localparam logic [1:0] MXA_CYC_EXT = 2'h2;
    localparam logic [1:0] MXA_CYC_LONG = 2'h3;

    // Reset values and the all-ones fill byte
    localparam logic [7:0] MXA_BYTE_RST = 8'h00;
    localparam logic [4:0] MXA_FLAGS_RST = 5'h00;
    localparam logic [7:0] MXA_NIB_ONES = 8'hFF;

    typedef enum logic [4:0] {
        MXA_OP_NOP = 5'h00,
        MXA_OP_SKIP_NULL = 5'h01,
        MXA_OP_SKIP_NULL_LOAD = 5'h02,
        MXA_OP_SKIP_NONNULL = 5'h03,
        MXA_OP_SKIP_BIT_NULL = 5'h04,
        MXA_OP_SKIP_BIT_NONNULL = 5'h05,
        MXA_OP_INCR_SKIP = 5'h06,
        MXA_OP_DECR_SKIP = 5'h07,
        MXA_OP_INCR_SKIP_W = 5'h08,
        MXA_OP_DECR_SKIP_W = 5'h09,
        MXA_OP_TRD_PAGED = 5'h0A,
        MXA_OP_TRD_FINAL = 5'h0B,
        MXA_OP_TRD_PAGED_INC = 5'h0C,
        MXA_OP_TRD_FINAL_INC = 5'h0D,
        MXA_OP_CLEAR_BYTE = 5'h0E,
        MXA_OP_FILL_BYTE = 5'h0F,
        MXA_OP_NIB_EXCH = 5'h10,
        MXA_OP_NIB_EXCH_W = 5'h11,
        MXA_OP_ADC_W = 5'h12,
        MXA_OP_ADC_MEM = 5'h13,
        MXA_OP_SUM_W = 5'h14,
        MXA_OP_SUM_IMM = 5'h15,
        MXA_OP_SUM_MEM = 5'h16,
        MXA_OP_CONJ_W = 5'h17,
        MXA_OP_CONJ_IMM = 5'h18,
        MXA_OP_CONJ_MEM = 5'h19
    } mxa_op_t;

    typedef enum logic [1:0] {
        MXA_ST_IDLE = 2'b01,
        MXA_ST_RUN = 2'b10
    } mxa_state_t;

endpackage

// ===== design/mxa_exec.sv
// Execution unit for extended skip, table read, misc and add/and operations
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Extended skips take two cycles, three when the next instruction is skipped.
// - Extended instructions that write the program counter low byte take three cycles.
// - Long byte tests skip on zero or nonzero byte, flags untouched.
// - Long bit tests skip on the selected bit zero or one, flags untouched.
// - Skip-if-null-with-load copies the byte to wreg and skips on zero.
// - Increment or decrement memory byte, write back, skip when result zero.
// - Register variants put inc/dec value in wreg, skip when zero.
// - Paged table read splits the program word into table-high and memory, three cycles.
// - Final-page table read uses the last program page, three cycles.
// - Pre-increment table reads bump the pointer first, then read, three cycles.
// - Nibble exchange swaps byte halves in memory, two cycles, no flags.
// - Nibble exchange to wreg puts swapped byte in wreg, two cycles, no flags.
// - Add-with-carry to wreg sums wreg, byte and carry; five flags updated.
// - Add-with-carry to memory stores the same sum in memory; five flags.
// - Add to wreg sums wreg and byte without carry; five flags.
// - Add-immediate sums wreg and immediate into wreg; five flags.
// - Add to memory writes wreg plus byte to memory; five flags.
// - AND to wreg writes wreg AND byte to wreg; zero flag only.
// - AND-immediate writes wreg AND immediate to wreg; zero flag only.
// - AND to memory writes wreg AND byte to memory; zero flag only.
// - Long byte clear writes zero, two cycles, flags unchanged.
module mxa_exec
    import mxa_pkg::*;
#(
    parameter int DMEM_AW = 8,
    parameter int PMEM_AW = 10,
    parameter int PMEM_DW = 16
)
(
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Execution state
    output logic busy_o
);

    localparam int PAGE_W = PMEM_AW - 8;

    // ==========================================================
    // Storage
    logic [7:0] dmem [2**DMEM_AW];
    logic [PMEM_DW-1:0] pmem [2**PMEM_AW];

    mxa_state_t state;
    logic [1:0] cyc_left;
    logic [1:0] last_cycles;
    logic skip_pending;
    mxa_op_t cur_op;
    logic [7:0] cur_arg;
    logic [2:0] cur_bit;
    logic cur_nop;
    logic [31:0] cmd_word;

    logic [7:0] wreg;
    logic [4:0] flags;
    logic [7:0] table_pointer_reg;
    logic [7:0] table_high_byte_reg;
    logic [PAGE_W-1:0] page;
    logic [15:0] pc;
    logic [DMEM_AW-1:0] dbg_daddr;
    logic [PMEM_AW-1:0] dbg_paddr;

    // ==========================================================
    // Arithmetic helpers
    function automatic logic [12:0] add_flags(input logic [7:0] a,
                                              input logic [7:0] b,
                                              input logic cin);
        logic [8:0] sum;
        logic [4:0] lo;
        logic ov;
        logic [4:0] f;
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        ov = (a[7] == b[7]) && (sum[7] != a[7]);
        f = MXA_FLAGS_RST;
        f[MXA_F_C] = sum[8];
        f[MXA_F_AC] = lo[4];
        f[MXA_F_Z] = (sum[7:0] == MXA_BYTE_RST);
        f[MXA_F_OV] = ov;
        f[MXA_F_SC] = ov ^ sum[7];
        add_flags = {f, sum[7:0]};
    endfunction

    function automatic logic [7:0] mem_index(input logic [7:0] a);
        mem_index = a;
    endfunction

    // ==========================================================
    // Operand fetch; the PC low byte appears at its alias address
    logic [7:0] mem_byte;
    always_comb
    begin
        if (cur_arg == MXA_PCL_MEM_ADDR)
            mem_byte = pc[7:0];
        else
            mem_byte = dmem[cur_arg[DMEM_AW-1:0]];
    end

    // ==========================================================
    // Instruction evaluation, held stable while running
    logic ex_wr_mem;
    logic [7:0] ex_mem_val;
    logic ex_wr_w;
    logic [7:0] ex_w_val;
    logic [4:0] ex_flags;
    logic ex_skip;
    logic ex_wr_tbl;
    logic [7:0] ex_table_high_byte_reg;
    logic [7:0] ex_table_pointer_reg;
    logic ex_extended;
    logic [1:0] ex_cycles;
    logic [12:0] sum_res;
    logic [7:0] conj_val;
    logic [7:0] tptr;
    logic [PAGE_W-1:0] tpage;
    logic [PMEM_DW-1:0] tword;

    always_comb
    begin
        ex_wr_mem = 1'b0;
        ex_mem_val = mem_byte;
        ex_wr_w = 1'b0;
        ex_w_val = wreg;
        ex_flags = flags;
        ex_skip = 1'b0;
        ex_wr_tbl = 1'b0;
        ex_table_high_byte_reg = table_high_byte_reg;
        ex_table_pointer_reg = table_pointer_reg;
        ex_extended = 1'b1;
        sum_res = add_flags(wreg, mem_byte, 1'b0);
        conj_val = wreg & mem_byte;
        tptr = table_pointer_reg;
        tpage = page;
        tword = pmem[{tpage, tptr}];
        case (cur_op)
            MXA_OP_SKIP_NULL:
                ex_skip = (mem_byte == MXA_BYTE_RST);
            MXA_OP_SKIP_NONNULL:
                ex_skip = (mem_byte != MXA_BYTE_RST);
            MXA_OP_SKIP_NULL_LOAD:
            begin
                ex_wr_w = 1'b1;
                ex_w_val = mem_byte;
                ex_skip = (mem_byte == MXA_BYTE_RST);
            end
            MXA_OP_SKIP_BIT_NULL:
                ex_skip = ~mem_byte[cur_bit];
            MXA_OP_SKIP_BIT_NONNULL:
                ex_skip = mem_byte[cur_bit];
            MXA_OP_INCR_SKIP, MXA_OP_DECR_SKIP:
            begin
                ex_wr_mem = 1'b1;
                ex_mem_val = (cur_op == MXA_OP_INCR_SKIP) ?
                    mem_byte + 8'h01 : mem_byte - 8'h01;
                ex_skip = (ex_mem_val == MXA_BYTE_RST);
            end
            MXA_OP_INCR_SKIP_W, MXA_OP_DECR_SKIP_W:
            begin
                ex_wr_w = 1'b1;
                ex_w_val = (cur_op == MXA_OP_INCR_SKIP_W) ?
                    mem_byte + 8'h01 : mem_byte - 8'h01;
                ex_skip = (ex_w_val == MXA_BYTE_RST);
            end
            MXA_OP_TRD_PAGED, MXA_OP_TRD_FINAL,
            MXA_OP_TRD_PAGED_INC, MXA_OP_TRD_FINAL_INC:
            begin
                if (cur_op == MXA_OP_TRD_PAGED_INC ||
                    cur_op == MXA_OP_TRD_FINAL_INC)
                    tptr = table_pointer_reg + 8'h01;
                if (cur_op == MXA_OP_TRD_FINAL ||
                    cur_op == MXA_OP_TRD_FINAL_INC)
                    tpage = '1;
                tword = pmem[{tpage, tptr}];
                ex_table_pointer_reg = tptr;
                ex_wr_tbl = 1'b1;
                ex_table_high_byte_reg = tword[15:8];
                ex_wr_mem = 1'b1;
                ex_mem_val = tword[7:0];
            end
            MXA_OP_CLEAR_BYTE:
            begin
                ex_wr_mem = 1'b1;
                ex_mem_val = MXA_BYTE_RST;
            end
            MXA_OP_FILL_BYTE:
            begin
                ex_wr_mem = 1'b1;
                ex_mem_val = MXA_NIB_ONES;
            end
            MXA_OP_NIB_EXCH:
            begin
                ex_wr_mem = 1'b1;
                ex_mem_val = {mem_byte[3:0], mem_byte[7:4]};
            end
            MXA_OP_NIB_EXCH_W:
            begin
                ex_wr_w = 1'b1;
                ex_w_val = {mem_byte[3:0], mem_byte[7:4]};
            end
            MXA_OP_ADC_W, MXA_OP_ADC_MEM:
            begin
                ex_extended = 1'b0;
                sum_res = add_flags(wreg, mem_byte, flags[MXA_F_C]);
                ex_flags = sum_res[12:8];
                ex_wr_w = (cur_op == MXA_OP_ADC_W);
                ex_wr_mem = (cur_op == MXA_OP_ADC_MEM);
                ex_w_val = sum_res[7:0];
                ex_mem_val = sum_res[7:0];
            end
            MXA_OP_SUM_W, MXA_OP_SUM_MEM, MXA_OP_SUM_IMM:
            begin
                ex_extended = 1'b0;
                if (cur_op == MXA_OP_SUM_IMM)
                    sum_res = add_flags(wreg, cur_arg, 1'b0);
                ex_flags = sum_res[12:8];
                ex_wr_w = (cur_op != MXA_OP_SUM_MEM);
                ex_wr_mem = (cur_op == MXA_OP_SUM_MEM);
                ex_w_val = sum_res[7:0];
                ex_mem_val = sum_res[7:0];
            end
            MXA_OP_CONJ_W, MXA_OP_CONJ_IMM, MXA_OP_CONJ_MEM:
            begin
                ex_extended = 1'b0;
                if (cur_op == MXA_OP_CONJ_IMM)
                    conj_val = wreg & cur_arg;
                ex_flags[MXA_F_Z] = (conj_val == MXA_BYTE_RST);
                ex_wr_w = (cur_op != MXA_OP_CONJ_MEM);
                ex_wr_mem = (cur_op == MXA_OP_CONJ_MEM);
                ex_w_val = conj_val;
                ex_mem_val = conj_val;
            end
            default:
                ex_extended = 1'b0;
        endcase
        if (cur_nop)
        begin
            ex_wr_mem = 1'b0;
            ex_wr_w = 1'b0;
            ex_wr_tbl = 1'b0;
            ex_skip = 1'b0;
            ex_flags = flags;
            ex_extended = 1'b0;
        end
    end

    // Cycle count of the current instruction
    always_comb
    begin
        if (!ex_extended)
            ex_cycles = MXA_CYC_BASIC;
        else if (ex_wr_tbl)
            ex_cycles = MXA_CYC_LONG;
        else if (ex_wr_mem && cur_arg == MXA_PCL_MEM_ADDR)
            ex_cycles = MXA_CYC_LONG;
        else if (ex_skip)
            ex_cycles = MXA_CYC_LONG;
        else
            ex_cycles = MXA_CYC_EXT;
    end

    // ==========================================================
    // APB slave: one wait state, writes land on the completing edge
    logic acc_phase;
    logic wr_done;
    logic cmd_issue;
    logic commit;
    assign acc_phase = psel_i && penable_i;
    assign wr_done = acc_phase && pready_o && pwrite_i && !pslverr_o;
    assign cmd_issue = wr_done && paddr_i == MXA_CMD_ADDR &&
                       state == MXA_ST_IDLE;
    assign commit = state == MXA_ST_RUN && cyc_left == 2'h1;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a <= MXA_PDATA_ADDR) && (a[1:0] == 2'b00);
    endfunction

    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = '0;
        if (paddr_i == MXA_CMD_ADDR)
            rd_val = cmd_word;
        else if (paddr_i == MXA_STATUS_ADDR)
        begin
            rd_val[MXA_ST_BUSY] = (state == MXA_ST_RUN);
            rd_val[MXA_ST_SKIP] = skip_pending;
            rd_val[MXA_ST_CYC_LSB +: 2] = last_cycles;
        end
        else if (paddr_i == MXA_WREG_ADDR)
            rd_val[7:0] = wreg;
        else if (paddr_i == MXA_FLAGS_ADDR)
            rd_val[4:0] = flags;
        else if (paddr_i == MXA_TABLE_POINTER_REG_ADDR)
            rd_val[7:0] = table_pointer_reg;
        else if (paddr_i == MXA_TABLE_HIGH_BYTE_REG_ADDR)
            rd_val[7:0] = table_high_byte_reg;
        else if (paddr_i == MXA_PAGE_ADDR)
            rd_val[PAGE_W-1:0] = page;
        else if (paddr_i == MXA_PC_ADDR)
            rd_val[15:0] = pc;
        else if (paddr_i == MXA_DADDR_ADDR)
            rd_val[DMEM_AW-1:0] = dbg_daddr;
        else if (paddr_i == MXA_DDATA_ADDR)
            rd_val[7:0] = dmem[dbg_daddr];
        else if (paddr_i == MXA_PADDR_ADDR)
            rd_val[PMEM_AW-1:0] = dbg_paddr;
        else if (paddr_i == MXA_PDATA_ADDR)
            rd_val[PMEM_DW-1:0] = pmem[dbg_paddr];
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end
        else if (ce_i)
        begin
            if (acc_phase && !pready_o)
            begin
                pready_o <= 1'b1;
                pslverr_o <= !addr_ok(paddr_i);
                prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
            end
            else
            begin
                pready_o <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Sequencer; a command is refused while busy
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= MXA_ST_IDLE;
            cyc_left <= 2'h0;
            busy_o <= 1'b0;
            cur_op <= MXA_OP_NOP;
            cur_arg <= MXA_BYTE_RST;
            cur_bit <= 3'h0;
            cur_nop <= 1'b0;
            cmd_word <= '0;
        end
        else if (ce_i)
        begin
            case (state)
                MXA_ST_IDLE:
                    if (cmd_issue)
                    begin
                        cmd_word <= pwdata_i;
                        cur_op <= mxa_op_t'(pwdata_i[MXA_CMD_OP_LSB +: 5]);
                        cur_arg <= pwdata_i[MXA_CMD_ARG_LSB +: 8];
                        cur_bit <= pwdata_i[MXA_CMD_BIT_LSB +: 3];
                        cur_nop <= skip_pending;
                        cyc_left <= 2'h0;
                        state <= MXA_ST_RUN;
                        busy_o <= 1'b1;
                    end
                MXA_ST_RUN:
                    if (cyc_left == 2'h0)
                    begin
                        cyc_left <= ex_cycles;
                        if (ex_cycles == 2'h1)
                        begin
                            state <= MXA_ST_IDLE;
                            busy_o <= 1'b0;
                        end
                    end
                    else if (commit)
                    begin
                        state <= MXA_ST_IDLE;
                        busy_o <= 1'b0;
                    end
                    else
                        cyc_left <= cyc_left - 2'h1;
                default:
                    state <= MXA_ST_IDLE;
            endcase
        end
    end

    // Results land on the final cycle of the instruction
    logic finish;
    assign finish = state == MXA_ST_RUN &&
                    ((cyc_left == 2'h0 && ex_cycles == 2'h1) || commit);

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wreg <= MXA_BYTE_RST;
            flags <= MXA_FLAGS_RST;
            table_pointer_reg <= MXA_BYTE_RST;
            table_high_byte_reg <= MXA_BYTE_RST;
            page <= '0;
            pc <= '0;
            skip_pending <= 1'b0;
            last_cycles <= 2'h0;
        end
        else if (ce_i)
        begin
            if (finish)
            begin
                skip_pending <= ex_skip;
                last_cycles <= ex_cycles;
                flags <= ex_flags;
                if (ex_wr_w)
                    wreg <= ex_w_val;
                if (ex_wr_tbl)
                begin
                    table_high_byte_reg <= ex_table_high_byte_reg;
                    table_pointer_reg <= ex_table_pointer_reg;
                end
                if (ex_wr_mem && cur_arg == MXA_PCL_MEM_ADDR)
                    pc[7:0] <= ex_mem_val;
                else
                    pc <= pc + 16'h0001;
            end
            else if (wr_done && state == MXA_ST_IDLE)
            begin
                if (paddr_i == MXA_WREG_ADDR)
                    wreg <= pwdata_i[7:0];
                else if (paddr_i == MXA_FLAGS_ADDR)
                    flags <= pwdata_i[4:0];
                else if (paddr_i == MXA_TABLE_POINTER_REG_ADDR)
                    table_pointer_reg <= pwdata_i[7:0];
                else if (paddr_i == MXA_PAGE_ADDR)
                    page <= pwdata_i[PAGE_W-1:0];
                else if (paddr_i == MXA_PC_ADDR)
                    pc <= pwdata_i[15:0];
            end
        end
    end

    // Memory and debug pointers; arrays carry no reset
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dbg_daddr <= '0;
            dbg_paddr <= '0;
        end
        else if (ce_i && wr_done && state == MXA_ST_IDLE)
        begin
            if (paddr_i == MXA_DADDR_ADDR)
                dbg_daddr <= pwdata_i[DMEM_AW-1:0];
            else if (paddr_i == MXA_PADDR_ADDR)
                dbg_paddr <= pwdata_i[PMEM_AW-1:0];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (ce_i)
        begin
            if (finish && ex_wr_mem && cur_arg != MXA_PCL_MEM_ADDR)
                dmem[mem_index(cur_arg)] <= ex_mem_val;
            else if (wr_done && state == MXA_ST_IDLE &&
                     paddr_i == MXA_DDATA_ADDR)
                dmem[dbg_daddr] <= pwdata_i[7:0];
            if (wr_done && state == MXA_ST_IDLE && paddr_i == MXA_PDATA_ADDR)
                pmem[dbg_paddr] <= pwdata_i[PMEM_DW-1:0];
        end
    end

endmodule

`default_nettype wire

// ===== sim/mxa_exec_properties.sv
// Port-level properties of the execution unit
`timescale 1ns/1ps
`default_nettype none
module mxa_exec_properties
    import mxa_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // APB and state
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic busy_o
);
    // ====
    // Checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_wait;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_cmd;
        psel_i && penable_i && pready_o && pwrite_i
            && paddr_i == MXA_CMD_ADDR && !busy_o;
    endsequence
    a_ready_wait: assert property (s_wait |=> pready_o)
        else $error("no ready after one wait state");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_ready_cause: assert property (pready_o |-> $past(penable_i))
        else $error("ready without an access phase");
    a_idle_quiet: assert property (!penable_i |-> !pready_o)
        else $error("ready outside access");
    a_err_decode: assert property (pready_o |->
        pslverr_o == (paddr_i > 8'h2C || paddr_i[1:0] != 2'h0))
        else $error("error response mismatch");
    a_err_alone: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_busy_start: assert property (s_cmd |=> busy_o)
        else $error("command did not start");
    // Basic ops leave after one busy cycle; extended ones hold for N+1
    a_busy_span: assert property
        ($rose(busy_o) |=> !busy_o or (busy_o[*2] ##1 !busy_o)
            or (busy_o[*3] ##1 !busy_o))
        else $error("execution length out of range");
endmodule
bind mxa_exec mxa_exec_properties u_props (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .busy_o(busy_o)
);
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) checks_done++; if ((g) !== (e)) begin \
    $display("[ERR] %s exp %h got %h", n, e, g); err_count++; end
module tb
    import mxa_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic pready_o, pslverr_o, busy_o;
    integer err_count = 0, checks_done = 0, seed = 32'hD3861EA2;
    logic [32:0] notes[$];
    logic [32:0] note;
    logic [7:0] w, m, tp, ar, bb, ew, em, et, eh = 8'h00;
    logic [4:0] fl, ef, h, k;
    logic [8:0] s;
    logic [1:0] pg, cy;
    logic [2:0] b;
    logic [15:0] wd;
    logic sk, ov, c, inc, fin;
    always #10 clock_i = ~clock_i;
    mxa_exec dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o));
    // ====
    // Bus tasks and result monitor
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i);
        while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        notes.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic run(input mxa_op_t op, input logic [7:0] a,
        input logic [2:0] bi);
        apb(1'b1, MXA_CMD_ADDR, {11'h0, op, 5'h0, bi, a});
        // Writes during execution are dropped, so wait it out
        do @(posedge clock_i);
        while (busy_o !== 1'b0);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
        begin
            note = notes.pop_front();
            `CHK("pslverr", note[32], pslverr_o)
            if (!note[32])
            begin
                `CHK("prdata", note[31:0], prdata_o)
            end
        end
    end
    // Run takes some 6000 cycles; 50000 leaves ample margin
    initial
    begin
        #1000000;
        err_count++;
        end_of_test();
    end
    // ====
    // Scenarios
    initial
    begin
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(8'h30, {1'b1, 32'h0});
        rd(8'h05, {1'b1, 32'h0});
        apb(1'b1, MXA_PC_ADDR, 32'h1234);
        run(MXA_OP_CLEAR_BYTE, MXA_PCL_MEM_ADDR, 3'h0);
        rd(MXA_STATUS_ADDR, {27'h0, 2'h3, 4'h0});
        rd(MXA_PC_ADDR, {17'h0, 16'h1200});
        for (int r = 0; r < 75; r++)
        begin
            k = 5'(r % 25 + 1);
            {w, m, tp, ar} = $random(seed);
            {fl, pg, b, wd} = 26'($random(seed));
            // Bias toward the values that make skips happen
            if (m[7:6] == 2'h0)
                m = (m[1:0] == 2'h0) ? 8'h00 : m[0] ? 8'hFF : 8'h01;
            if (k != 5'h15 && k != 5'h18)
                ar = 8'h10;
            inc = k == 5'h0C || k == 5'h0D;
            fin = k == 5'h0B || k == 5'h0D;
            apb(1'b1, MXA_WREG_ADDR, {24'h0, w});
            apb(1'b1, MXA_FLAGS_ADDR, {27'h0, fl});
            apb(1'b1, MXA_TABLE_POINTER_REG_ADDR, {24'h0, tp});
            apb(1'b1, MXA_PAGE_ADDR, {30'h0, pg});
            apb(1'b1, MXA_DADDR_ADDR, 32'h10);
            apb(1'b1, MXA_DDATA_ADDR, {24'h0, m});
            apb(1'b1, MXA_PADDR_ADDR, {22'h0, fin ? 2'h3 : pg, tp + 8'(inc)});
            apb(1'b1, MXA_PDATA_ADDR, {16'h0, wd});
            run(mxa_op_t'(k), ar, b);
            ew = w;
            em = m;
            ef = fl;
            et = tp + 8'(inc);
            sk = 1'b0;
            cy = 2'h2;
            bb = (k == 5'h15 || k == 5'h18) ? ar : m;
            c = (k == 5'h12 || k == 5'h13) && fl[MXA_F_C];
            s = w + bb + 9'(c);
            h = w[3:0] + bb[3:0] + 5'(c);
            ov = (w[7] == bb[7]) && (s[7] != w[7]);
            case (k)
                5'h01: sk = m == 8'h00;
                5'h02: {ew, sk} = {m, m == 8'h00};
                5'h03: sk = m != 8'h00;
                5'h04: sk = !m[b];
                5'h05: sk = m[b];
                5'h06: em = m + 8'h01;
                5'h07: em = m - 8'h01;
                5'h08: ew = m + 8'h01;
                5'h09: ew = m - 8'h01;
                5'h0E: em = 8'h00;
                5'h0F: em = 8'hFF;
                5'h10: em = {m[3:0], m[7:4]};
                5'h11: ew = {m[3:0], m[7:4]};
                5'h12, 5'h14, 5'h15: ew = s[7:0];
                5'h13, 5'h16: em = s[7:0];
                5'h17, 5'h18: ew = w & bb;
                5'h19: em = w & bb;
                default: {eh, em, cy} = {wd, 2'h3};
            endcase
            if (k >= 5'h06 && k <= 5'h09)
                sk = (k < 5'h08 ? em : ew) == 8'h00;
            if (k >= 5'h12 && k <= 5'h16)
                ef = {ov ^ s[7], ov, s[7:0] == 8'h00, h[4], s[8]};
            if (k >= 5'h17)
                ef[MXA_F_Z] = (w & bb) == 8'h00;
            if (k >= 5'h12)
                cy = 2'h1;
            if (sk)
                cy = 2'h3;
            rd(MXA_STATUS_ADDR, {27'h0, cy, 2'h0, sk, 1'b0});
            rd(MXA_WREG_ADDR, {25'h0, ew});
            rd(MXA_FLAGS_ADDR, {28'h0, ef});
            rd(MXA_DDATA_ADDR, {25'h0, em});
            rd(MXA_TABLE_HIGH_BYTE_REG_ADDR, {25'h0, eh});
            rd(MXA_TABLE_POINTER_REG_ADDR, {25'h0, et});
            run(MXA_OP_SUM_IMM, 8'h01, 3'h0);
            rd(MXA_WREG_ADDR, {25'h0, sk ? ew : ew + 8'h01});
            rd(MXA_STATUS_ADDR, {27'h0, 2'h1, 4'h0});
        end
        @(posedge clock_i);
        end_of_test();
    end
endmodule
`default_nettype wire
